// ---- logic/system_control_registers.sv ----
// System control registers: calibration, pin functions, unlock, reset, mode.
`timescale 1ns/10ps
`default_nettype none
module system_control_registers (
  input  wire logic        CLK_SYS,
  input  wire logic        RSTN,
  input  wire logic [7:0]  REG_ADDR,
  input  wire logic [15:0] REG_WDATA,
  input  wire logic        REG_WR,
  input  wire logic        REG_RD,
  output logic [15:0]      REG_RDATA,
  input  wire logic        FAST_OSC_CLK,
  input  wire logic        SLOW_OSC_CLK,
  input  wire logic        FAST_OSC_CAL_ENABLE,
  input  wire logic        INTR_LEVEL,
  input  wire logic        LEGACY_INT,
  input  wire logic        LEGACY_DATA,
  input  wire logic        SAMPLE_FRAME,
  input  wire logic        SLOT_A_PULSE,
  input  wire logic        SLOT_B_PULSE,
  input  wire logic        DATA_CYCLE_A,
  input  wire logic        DATA_CYCLE_B,
  input  wire logic        SAMPLE_DONE,
  input  wire logic        GENERAL_PIN_0_IN,
  input  wire logic        GENERAL_PIN_1_IN,
  output logic             GENERAL_PIN_0_OUT,
  output logic             GENERAL_PIN_1_OUT,
  output logic             GENERAL_PIN_0_OE_N,
  output logic             GENERAL_PIN_1_OE_N,
  output logic [6:0]       BUS_TARGET_ADDRESS,
  output logic [1:0]       MODE,
  output logic             SOFT_RESET_OUT
);
  import sysctl_pkg::*;

  cal_if cal ();

  // ----------------------------------------------------------------------
  // Synchronisers for pins and oscillators
  // ----------------------------------------------------------------------
  localparam int SYNC_N = 4;
  logic [SYNC_N-1:0] sync_a_reg, sync_b_reg;
  logic [SYNC_N-1:0] sync_a_next, sync_b_next;
  logic [1:0]        sync_c_reg, sync_c_next;
  logic              pin0_lvl, pin1_lvl, fast_lvl, slow_lvl;

  always_comb begin
    sync_a_next = {SLOW_OSC_CLK, FAST_OSC_CLK,
                   GENERAL_PIN_1_IN, GENERAL_PIN_0_IN};
    sync_b_next = sync_a_reg;
    sync_c_next = sync_b_reg[3:2];
  end

  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      sync_a_reg <= '0;
      sync_b_reg <= '0;
      sync_c_reg <= '0;
    end else begin
      sync_a_reg <= sync_a_next;
      sync_b_reg <= sync_b_next;
      sync_c_reg <= sync_c_next;
    end
  end

  assign pin0_lvl = sync_b_reg[0];
  assign pin1_lvl = sync_b_reg[1];
  assign fast_lvl = sync_b_reg[2];
  assign slow_lvl = sync_b_reg[3];

  // ----------------------------------------------------------------------
  // Register file and soft reset
  // ----------------------------------------------------------------------
  soft_state_t          sr_reg, sr_next;
  logic [FUNC_W-1:0]    func0_reg, func0_next, func1_reg, func1_next;
  logic [15:0]          unlock_reg, unlock_next;
  logic [ADDR_W-1:0]    addr_reg, addr_next;
  logic [1:0]           mode_reg, mode_next;
  logic [15:0]          rdata_reg, rdata_next;
  logic                 unlock_ok;

  always_comb begin
    case (unlock_reg)
      UNLOCK_ALWAYS: unlock_ok = 1'b1; // R10
      UNLOCK_PIN0:   unlock_ok = pin0_lvl; // R10
      UNLOCK_PIN1:   unlock_ok = pin1_lvl; // R10
      UNLOCK_BOTH:   unlock_ok = pin0_lvl & pin1_lvl; // R10
      default:       unlock_ok = 1'b0;
    endcase
  end

  always_comb begin
    sr_next     = sr_reg;
    func0_next  = func0_reg;
    func1_next  = func1_reg;
    unlock_next = unlock_reg;
    addr_next   = addr_reg;
    mode_next   = mode_reg;
    rdata_next  = rdata_reg;
    if (REG_RD) begin
      rdata_next = '0;
      if (REG_ADDR == OFS_TARGET_ADDR) begin
        rdata_next[ADDR_LSB +: ADDR_W] = addr_reg;
      end else if (REG_ADDR == OFS_OSC_RATIO) begin
        rdata_next[RATIO_W-1:0] = cal.ratio; // R1
      end else if (REG_ADDR == OFS_PIN_FUNC) begin
        rdata_next[PIN1_LSB +: FUNC_W] = func1_reg;
        rdata_next[PIN0_LSB +: FUNC_W] = func0_reg;
      end else if (REG_ADDR == OFS_UNLOCK) begin
        rdata_next = unlock_reg;
      end else if (REG_ADDR == OFS_SOFT_RESET) begin
        rdata_next[SOFT_RESET_BIT] = (sr_reg == SR_ACTIVE);
      end else if (REG_ADDR == OFS_MODE) begin
        rdata_next[1:0] = mode_reg;
      end
    end
    case (sr_reg)
      SR_IDLE: begin
        if (REG_WR) begin
          if (REG_ADDR == OFS_TARGET_ADDR) begin
            // A key byte other than the documented one leaves it alone.
            if (unlock_ok &&
                REG_WDATA[KEY_LSB +: 8] == ADDR_KEY_BYTE) begin // R10 R11
              addr_next = REG_WDATA[ADDR_LSB +: ADDR_W];
            end
          end else if (REG_ADDR == OFS_PIN_FUNC) begin
            func1_next = REG_WDATA[PIN1_LSB +: FUNC_W]; // R2
            func0_next = REG_WDATA[PIN0_LSB +: FUNC_W]; // R2
          end else if (REG_ADDR == OFS_UNLOCK) begin
            unlock_next = REG_WDATA;
          end else if (REG_ADDR == OFS_SOFT_RESET) begin
            if (REG_WDATA[SOFT_RESET_BIT]) begin
              sr_next = SR_ACTIVE; // R12
            end
          end else if (REG_ADDR == OFS_MODE) begin
            mode_next = REG_WDATA[1:0]; // R14
          end
        end
      end
      default: begin
        // The write has already been accepted, so the defaults land after.
        sr_next     = SR_IDLE; // R12 R13
        func0_next  = FUNC_RESET; // R13
        func1_next  = FUNC_RESET; // R13
        unlock_next = UNLOCK_RESET; // R13
        addr_next   = ADDR_RESET; // R13
        mode_next   = MODE_STANDBY; // R13 R14
      end
    endcase
  end

  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      sr_reg     <= SR_IDLE;
      func0_reg  <= FUNC_RESET;
      func1_reg  <= FUNC_RESET;
      unlock_reg <= UNLOCK_RESET;
      addr_reg   <= ADDR_RESET;
      mode_reg   <= MODE_STANDBY;
      rdata_reg  <= '0;
    end else begin
      sr_reg     <= sr_next;
      func0_reg  <= func0_next;
      func1_reg  <= func1_next;
      unlock_reg <= unlock_next;
      addr_reg   <= addr_next;
      mode_reg   <= mode_next;
      rdata_reg  <= rdata_next;
    end
  end

  assign REG_RDATA          = rdata_reg;
  assign BUS_TARGET_ADDRESS = addr_reg;
  assign MODE               = mode_reg;
  assign SOFT_RESET_OUT     = (sr_reg == SR_ACTIVE);

  // ----------------------------------------------------------------------
  // Oscillator ratio measurement
  // ----------------------------------------------------------------------
  assign cal.enable    = FAST_OSC_CAL_ENABLE;
  assign cal.clear     = (sr_reg == SR_ACTIVE);
  assign cal.fast_edge = fast_lvl & ~sync_c_reg[0];
  assign cal.slow_edge = slow_lvl & ~sync_c_reg[1];

  osc_ratio_counter u_ratio (
    .CLK_SYS (CLK_SYS),
    .RSTN    (RSTN),
    .cal     (cal)
  );

  // ----------------------------------------------------------------------
  // Pin function multiplexers
  // ----------------------------------------------------------------------
  logic [1:0] pin_out_reg, pin_out_next;
  logic [1:0] pin_oe_n_reg, pin_oe_n_next;
  logic [1:0] toggle_reg, toggle_next;
  logic [FUNC_W-1:0] fsel;
  logic              legacy;

  always_comb begin
    pin_out_next  = pin_out_reg;
    pin_oe_n_next = pin_oe_n_reg;
    toggle_next   = toggle_reg;
    fsel          = func0_reg;
    legacy        = LEGACY_INT;
    for (int i = 0; i < 2; i++) begin
      fsel   = (i == 0) ? func0_reg : func1_reg;
      legacy = (i == 0) ? LEGACY_INT : LEGACY_DATA;
      if (SAMPLE_DONE && fsel == FN_TOGGLE) begin
        toggle_next[i] = ~toggle_reg[i]; // R6
      end
      pin_oe_n_next[i] = 1'b0;
      case (fsel)
        FN_LEGACY:    pin_out_next[i] = legacy; // R8
        FN_INTERRUPT: pin_out_next[i] = INTR_LEVEL; // R2
        FN_FRAME:     pin_out_next[i] = SAMPLE_FRAME; // R3
        FN_PULSE_A:   pin_out_next[i] = SLOT_A_PULSE; // R4
        FN_PULSE_B:   pin_out_next[i] = SLOT_B_PULSE; // R4
        FN_PULSE_AB:  pin_out_next[i] = SLOT_A_PULSE | SLOT_B_PULSE; // R4
        FN_DATA_A:    pin_out_next[i] = DATA_CYCLE_A; // R5
        FN_DATA_B:    pin_out_next[i] = (i == 0)
                                      ? (DATA_CYCLE_A | DATA_CYCLE_B)
                                      : DATA_CYCLE_B; // R5
        FN_DATA_ANY:  pin_out_next[i] = DATA_CYCLE_A | DATA_CYCLE_B; // R5
        FN_TOGGLE:    pin_out_next[i] = toggle_next[i]; // R6
        FN_LOW:       pin_out_next[i] = 1'b0; // R7
        FN_HIGH:      pin_out_next[i] = 1'b1; // R7
        FN_SLOW_CLK:  pin_out_next[i] = slow_lvl; // R7
        default: begin
          // Unsupported codes release the pin rather than drive junk.
          pin_out_next[i]  = 1'b0;
          pin_oe_n_next[i] = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      pin_out_reg  <= '0;
      pin_oe_n_reg <= '1;
      toggle_reg   <= '0;
    end else begin
      pin_out_reg  <= pin_out_next;
      pin_oe_n_reg <= pin_oe_n_next;
      toggle_reg   <= toggle_next;
    end
  end

  assign GENERAL_PIN_0_OUT  = pin_out_reg[0];
  assign GENERAL_PIN_1_OUT  = pin_out_reg[1];
  assign GENERAL_PIN_0_OE_N = pin_oe_n_reg[0];
  assign GENERAL_PIN_1_OE_N = pin_oe_n_reg[1];

endmodule
`default_nettype wire

// ---- logic/sysctl_pkg.sv ----
// Constants, field layouts and codes for the system control registers.
//
// Contract
// R1: Calibration counts fast cycles over two slow periods.
// R2: Two 5-bit pin selectors, reset zero, 0x01 interrupt.
// R3: Code 0x02 frames first slot start to last end.
// R4: Codes 0x05/0x06/0x07 copy LED pulses A/B/both.
// R5: Codes 0x0C/0x0D/0x0E flag data cycles.
// R6: Code 0x0F toggles pin once per sample.
// R7: Codes 0x10/0x11 constant levels, 0x13 slow clock.
// R8: Code 0x00 gives legacy pin behaviour.
// R9: Host programs only listed pin codes.
// R10: Address change gated by unlock code and pins.
// R11: Host writes 0xAD key byte with address.
// R12: Soft reset bit resets device, self clears.
// R13: Reset write acknowledged, then defaults and standby.
// R14: Two-bit mode: standby, program, normal; resets standby.
// R15: Host writes reserved zero, never mode three.
package sysctl_pkg;

  // ----------------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------------
  localparam logic [7:0] OFS_TARGET_ADDR = 8'h09;
  localparam logic [7:0] OFS_OSC_RATIO   = 8'h0A;
  localparam logic [7:0] OFS_PIN_FUNC    = 8'h0B;
  localparam logic [7:0] OFS_UNLOCK      = 8'h0D;
  localparam logic [7:0] OFS_SOFT_RESET  = 8'h0F;
  localparam logic [7:0] OFS_MODE        = 8'h10;

  // ----------------------------------------------------------------------
  // Field layouts and reset values
  // ----------------------------------------------------------------------
  localparam int         RATIO_W         = 12;
  localparam int         FUNC_W          = 5;
  localparam int         PIN1_LSB        = 8;
  localparam int         PIN0_LSB        = 0;
  localparam int         ADDR_W          = 7;
  localparam int         ADDR_LSB        = 1;
  localparam int         KEY_LSB         = 8;
  localparam logic [7:0] ADDR_KEY_BYTE   = 8'hAD;
  localparam logic [6:0] ADDR_RESET      = 7'h64;
  localparam logic [15:0] UNLOCK_RESET   = 16'h0000;
  localparam logic [FUNC_W-1:0] FUNC_RESET = 5'h00;
  localparam int         SOFT_RESET_BIT  = 0;
  localparam logic [1:0] MODE_STANDBY    = 2'h0;
  localparam logic [1:0] MODE_PROGRAM    = 2'h1;
  localparam logic [1:0] MODE_NORMAL     = 2'h2;

  // ----------------------------------------------------------------------
  // Unlock codes
  // ----------------------------------------------------------------------
  localparam logic [15:0] UNLOCK_ALWAYS  = 16'h04AD;
  localparam logic [15:0] UNLOCK_PIN0    = 16'h44AD;
  localparam logic [15:0] UNLOCK_PIN1    = 16'h84AD;
  localparam logic [15:0] UNLOCK_BOTH    = 16'hC4AD;

  // ----------------------------------------------------------------------
  // Pin function codes
  // ----------------------------------------------------------------------
  localparam logic [4:0] FN_LEGACY       = 5'h00;
  localparam logic [4:0] FN_INTERRUPT    = 5'h01;
  localparam logic [4:0] FN_FRAME        = 5'h02;
  localparam logic [4:0] FN_PULSE_A      = 5'h05;
  localparam logic [4:0] FN_PULSE_B      = 5'h06;
  localparam logic [4:0] FN_PULSE_AB     = 5'h07;
  localparam logic [4:0] FN_DATA_A       = 5'h0C;
  localparam logic [4:0] FN_DATA_B       = 5'h0D;
  localparam logic [4:0] FN_DATA_ANY     = 5'h0E;
  localparam logic [4:0] FN_TOGGLE       = 5'h0F;
  localparam logic [4:0] FN_LOW          = 5'h10;
  localparam logic [4:0] FN_HIGH         = 5'h11;
  localparam logic [4:0] FN_SLOW_CLK     = 5'h13;

  typedef enum logic [1:0] {SR_IDLE, SR_ACTIVE} soft_state_t;
  typedef enum logic [1:0] {CAL_IDLE, CAL_ARM, CAL_COUNT} cal_state_t;

endpackage

// ---- logic/cal_if.sv ----
// Interface between the register block and the ratio counter.
`timescale 1ns/10ps
`default_nettype none
interface cal_if;
  logic        enable;
  logic        clear;
  logic        fast_edge;
  logic        slow_edge;
  logic [11:0] ratio;

  modport counter (input enable, input clear, input fast_edge,
                   input slow_edge, output ratio);
  modport ctrl    (output enable, output clear, output fast_edge,
                   output slow_edge, input ratio);
endinterface
`default_nettype wire

// ---- logic/osc_ratio_counter.sv ----
// Counter that measures fast oscillator cycles over two slow periods.
`timescale 1ns/10ps
`default_nettype none
module osc_ratio_counter (
  input  wire logic CLK_SYS,
  input  wire logic RSTN,
  cal_if.counter    cal
);
  import sysctl_pkg::*;

  cal_state_t           state_reg, state_next;
  logic [RATIO_W-1:0]   cnt_reg, cnt_next;
  logic                 period_reg, period_next;
  logic [RATIO_W-1:0]   ratio_reg, ratio_next;
  logic [RATIO_W-1:0]   cnt_inc;

  assign cal.ratio = ratio_reg;

  // ----------------------------------------------------------------------
  // Measurement
  // ----------------------------------------------------------------------
  always_comb begin
    state_next  = state_reg;
    cnt_next    = cnt_reg;
    period_next = period_reg;
    ratio_next  = ratio_reg;
    // Saturate so a stuck slow clock never wraps into a plausible value.
    cnt_inc = (cnt_reg == {RATIO_W{1'b1}}) ? cnt_reg
            : cnt_reg + RATIO_W'(cal.fast_edge);
    case (state_reg)
      CAL_IDLE: begin
        if (cal.enable) begin
          state_next = CAL_ARM;
        end
      end
      CAL_ARM: begin
        if (cal.slow_edge) begin
          state_next  = CAL_COUNT;
          cnt_next    = '0;
          period_next = 1'b0;
        end
      end
      default: begin
        cnt_next = cnt_inc; // R1
        if (cal.slow_edge) begin
          if (period_reg) begin
            ratio_next = cnt_inc; // R1
            state_next = CAL_ARM;
          end else begin
            period_next = 1'b1;
          end
        end
      end
    endcase
    if (!cal.enable) begin
      state_next = CAL_IDLE;
    end
    if (cal.clear) begin
      state_next = CAL_IDLE;
      ratio_next = '0;
    end
  end

  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      state_reg  <= CAL_IDLE;
      cnt_reg    <= '0;
      period_reg <= 1'b0;
      ratio_reg  <= '0;
    end else begin
      state_reg  <= state_next;
      cnt_reg    <= cnt_next;
      period_reg <= period_next;
      ratio_reg  <= ratio_next;
    end
  end

endmodule
`default_nettype wire

// ---- tb/sysctl_osc_model.sv ----
// Free-running fast and slow oscillator model feeding the calibration.
`timescale 1ns/10ps
`default_nettype none
module sysctl_osc_model #(
  parameter real FAST_HALF = 15.625,
  parameter real SLOW_HALF = 15625.0
) (
  output var logic fast_clk,
  output var logic slow_clk
);
  // ----------------------------------------------------------------------
  // Oscillators
  // ----------------------------------------------------------------------
  // The fast clock starts off phase so no edge lines up with the bus clock.
  initial begin
    slow_clk = 1'b0;
    fast_clk = 1'b0;
    #3.7;
    forever #(FAST_HALF) fast_clk = ~fast_clk;
  end
  always #(SLOW_HALF) slow_clk = ~slow_clk;
endmodule
`default_nettype wire

// ---- tb/sysctl_regs_monitor.sv ----
// Port checker for the system control registers.
`timescale 1ns/10ps
`default_nettype none
module sysctl_regs_monitor
  import sysctl_pkg::*;
(
  input wire logic        CLK_SYS,
  input wire logic        RSTN,
  input wire logic [7:0]  REG_ADDR,
  input wire logic [15:0] REG_WDATA,
  input wire logic        REG_WR,
  input wire logic        REG_RD,
  input wire logic [15:0] REG_RDATA,
  input wire logic        INTR_LEVEL,
  input wire logic        LEGACY_INT,
  input wire logic        SLOT_A_PULSE,
  input wire logic        GENERAL_PIN_0_OUT,
  input wire logic        GENERAL_PIN_1_OUT,
  input wire logic        GENERAL_PIN_0_OE_N,
  input wire logic        GENERAL_PIN_1_OE_N,
  input wire logic [6:0]  BUS_TARGET_ADDRESS,
  input wire logic [1:0]  MODE,
  input wire logic        SOFT_RESET_OUT
);
  // ----------------------------------------------------------------------
  // Shadow of the pin codes
  // ----------------------------------------------------------------------
  // The old copy resets to an unused code so pins count as settled only
  // once a code has been held across two edges.
  logic [4:0] fn0_reg, fn0_next, fn1_reg, fn1_next;
  logic [4:0] old0_reg, old0_next, old1_reg, old1_next;
  logic       set0, set1;
  assign set0 = fn0_reg == old0_reg;
  assign set1 = fn1_reg == old1_reg;
  always_comb begin
    fn0_next = fn0_reg;
    fn1_next = fn1_reg;
    old0_next = SOFT_RESET_OUT ? 5'h1F : fn0_reg;
    old1_next = SOFT_RESET_OUT ? 5'h1F : fn1_reg;
    if (SOFT_RESET_OUT) begin
      fn0_next = FN_LEGACY;
      fn1_next = FN_LEGACY;
    end else if (REG_WR && REG_ADDR == OFS_PIN_FUNC) begin
      fn0_next = REG_WDATA[4:0];
      fn1_next = REG_WDATA[12:8];
    end
  end
  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      fn0_reg <= FN_LEGACY;
      fn1_reg <= FN_LEGACY;
      old0_reg <= 5'h1F;
      old1_reg <= 5'h1F;
    end else begin
      fn0_reg <= fn0_next;
      fn1_reg <= fn1_next;
      old0_reg <= old0_next;
      old1_reg <= old1_next;
    end
  end
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RSTN);
  read_mode_a: assert property (
    REG_RD && REG_ADDR == OFS_MODE && !SOFT_RESET_OUT |=>
    REG_RDATA == {14'h0000, $past(MODE)}) else $error("Mode read wrong.");
  mode_write_a: assert property (
    REG_WR && REG_ADDR == OFS_MODE && !SOFT_RESET_OUT |=>
    MODE == $past(REG_WDATA[1:0])) else $error("Mode not written.");
  soft_pulse_a: assert property (
    REG_WR && REG_ADDR == OFS_SOFT_RESET && REG_WDATA[0] && !SOFT_RESET_OUT
    |=> SOFT_RESET_OUT ##1 (!SOFT_RESET_OUT && MODE == MODE_STANDBY &&
    BUS_TARGET_ADDRESS == ADDR_RESET)) else $error("Soft reset wrong.");
  soft_cause_a: assert property (
    $rose(SOFT_RESET_OUT) |-> $past(REG_WR) &&
    $past(REG_ADDR) == OFS_SOFT_RESET) else $error("Stray soft reset.");
  addr_hold_a: assert property (
    !(REG_WR && REG_ADDR == OFS_TARGET_ADDR &&
    REG_WDATA[15:8] == ADDR_KEY_BYTE) && !SOFT_RESET_OUT |=>
    $stable(BUS_TARGET_ADDRESS)) else $error("Address moved.");
  pin_high_a: assert property (
    set0 && fn0_reg == FN_HIGH |-> GENERAL_PIN_0_OUT && !GENERAL_PIN_0_OE_N)
    else $error("Pin 0 not high.");
  pin_low_a: assert property (
    set1 && fn1_reg == FN_LOW |-> !GENERAL_PIN_1_OUT && !GENERAL_PIN_1_OE_N)
    else $error("Pin 1 not low.");
  pulse_copy_a: assert property (
    set0 && fn0_reg == FN_PULSE_A |-> GENERAL_PIN_0_OUT == $past(SLOT_A_PULSE))
    else $error("Pulse copy wrong.");
  intr_route_a: assert property (
    set1 && fn1_reg == FN_INTERRUPT |-> GENERAL_PIN_1_OUT == $past(INTR_LEVEL))
    else $error("Interrupt route wrong.");
  legacy_int_a: assert property (
    set0 && fn0_reg == FN_LEGACY |-> GENERAL_PIN_0_OUT == $past(LEGACY_INT))
    else $error("Legacy pin wrong.");
  cover property (SOFT_RESET_OUT);
  cover property (set0 && fn0_reg == FN_PULSE_A && SLOT_A_PULSE);
  cover property (REG_WR && REG_ADDR == OFS_TARGET_ADDR);
endmodule
bind system_control_registers sysctl_regs_monitor mon (
  .CLK_SYS(CLK_SYS), .RSTN(RSTN), .REG_ADDR(REG_ADDR),
  .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD),
  .REG_RDATA(REG_RDATA), .INTR_LEVEL(INTR_LEVEL), .LEGACY_INT(LEGACY_INT),
  .SLOT_A_PULSE(SLOT_A_PULSE), .GENERAL_PIN_0_OUT(GENERAL_PIN_0_OUT),
  .GENERAL_PIN_1_OUT(GENERAL_PIN_1_OUT),
  .GENERAL_PIN_0_OE_N(GENERAL_PIN_0_OE_N),
  .GENERAL_PIN_1_OE_N(GENERAL_PIN_1_OE_N),
  .BUS_TARGET_ADDRESS(BUS_TARGET_ADDRESS), .MODE(MODE),
  .SOFT_RESET_OUT(SOFT_RESET_OUT));
`default_nettype wire

// ---- tb/system_control_registers_test.sv ----
// Self-checking bench for the system control registers.
`timescale 1ns/10ps
`default_nettype none
module system_control_registers_test;
  import sysctl_pkg::*;
  logic        clk_sys = 1'b0;
  logic        rstn = 1'b0;
  logic [7:0]  reg_addr = 8'h00;
  logic [15:0] reg_wdata = 16'h0000;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic        cal_en = 1'b0;
  logic        smp_done = 1'b0;
  logic [7:0]  src = 8'h00;
  logic [15:0] rdata, d;
  logic        fast_clk, slow_clk, p0_out, p1_out, p0_oe_n, p1_oe_n;
  logic        soft_out, lvl;
  logic [6:0]  target, addr_exp;
  logic [1:0]  mode;
  int          err_total = 0;
  int          tests_run = 0;
  int          n;
  logic [4:0]  codes [12] = '{FN_LEGACY, FN_INTERRUPT, FN_FRAME, FN_PULSE_A,
    FN_PULSE_B, FN_PULSE_AB, FN_DATA_A, FN_DATA_B, FN_DATA_ANY, FN_LOW,
    FN_HIGH, 5'h03};
  logic [7:0]  pats [3] = '{8'hA5, 8'h5A, 8'h00};
  logic [7:0]  offs [6] = '{OFS_PIN_FUNC, OFS_UNLOCK, OFS_SOFT_RESET,
    OFS_MODE, OFS_OSC_RATIO, OFS_TARGET_ADDR};
  // Entry: unlock code, key byte, pin 0 high, pin 1 high, change allowed.
  logic [26:0] ucase [9] = '{{16'h0000, 8'hAD, 3'h6},
    {UNLOCK_ALWAYS, 8'h00, 3'h6}, {UNLOCK_ALWAYS, 8'hAD, 3'h1},
    {UNLOCK_PIN0, 8'hAD, 3'h2}, {UNLOCK_PIN0, 8'hAD, 3'h5},
    {UNLOCK_PIN1, 8'hAD, 3'h4}, {UNLOCK_PIN1, 8'hAD, 3'h3},
    {UNLOCK_BOTH, 8'hAD, 3'h4}, {UNLOCK_BOTH, 8'hAD, 3'h7}};
  always #5 clk_sys = ~clk_sys;
  sysctl_osc_model osc (.fast_clk(fast_clk), .slow_clk(slow_clk));
  system_control_registers dut (
    .CLK_SYS(clk_sys), .RSTN(rstn), .REG_ADDR(reg_addr),
    .REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd),
    .REG_RDATA(rdata), .FAST_OSC_CLK(fast_clk), .SLOW_OSC_CLK(slow_clk),
    .FAST_OSC_CAL_ENABLE(cal_en), .INTR_LEVEL(src[7]), .LEGACY_INT(src[6]),
    .LEGACY_DATA(src[5]), .SAMPLE_FRAME(src[4]), .SLOT_A_PULSE(src[3]),
    .SLOT_B_PULSE(src[2]), .DATA_CYCLE_A(src[1]), .DATA_CYCLE_B(src[0]),
    .SAMPLE_DONE(smp_done), .GENERAL_PIN_0_IN(p0_oe_n ? 1'b0 : p0_out),
    .GENERAL_PIN_1_IN(p1_oe_n ? 1'b0 : p1_out), .GENERAL_PIN_0_OUT(p0_out),
    .GENERAL_PIN_1_OUT(p1_out), .GENERAL_PIN_0_OE_N(p0_oe_n),
    .GENERAL_PIN_1_OE_N(p1_oe_n), .BUS_TARGET_ADDRESS(target),
    .MODE(mode), .SOFT_RESET_OUT(soft_out));
  // ----------------------------------------------------------------------
  // Bus cycles and comparisons
  // ----------------------------------------------------------------------
  task automatic chk_word(input string nm, input logic [15:0] e, g);
    tests_run++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk_pin(input string nm, input logic [1:0] e, g);
    tests_run++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] %s expected %b seen %b", nm, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] v);
    @(negedge clk_sys);
    reg_addr = a;
    reg_wdata = v;
    reg_wr = 1'b1;
    @(negedge clk_sys);
    reg_wr = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(negedge clk_sys);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clk_sys);
    reg_rd = 1'b0;
    d = rdata;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [15:0] e);
    rd(a);
    chk_word($sformatf("reg %h", a), e, d);
  endtask
  task automatic chk_defaults;
    foreach (offs[i]) begin
      rd_chk(offs[i], i == 5 ? {8'h00, ADDR_RESET, 1'b0} : 16'h0000);
    end
  endtask
  // Expected {release, level} of a pin for a code and source pattern.
  function automatic logic [1:0] want(input logic [4:0] c, input logic p,
                                      input logic [7:0] s);
    case (c)
      FN_LEGACY:    return {1'b0, p ? s[5] : s[6]};
      FN_INTERRUPT: return {1'b0, s[7]};
      FN_FRAME:     return {1'b0, s[4]};
      FN_PULSE_A:   return {1'b0, s[3]};
      FN_PULSE_B:   return {1'b0, s[2]};
      FN_PULSE_AB:  return {1'b0, s[3] | s[2]};
      FN_DATA_A:    return {1'b0, s[1]};
      FN_DATA_B:    return {1'b0, s[0] | (!p & s[1])};
      FN_DATA_ANY:  return {1'b0, s[1] | s[0]};
      FN_LOW:       return 2'h0;
      FN_HIGH:      return 2'h1;
      default:      return 2'h2;
    endcase
  endfunction
  task automatic end_sim;
    if (err_total == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    #600000;
    err_total++;
    end_sim();
  end
  initial begin
    repeat (20) @(negedge clk_sys);
    rstn = 1'b1;
    chk_defaults();
    wr(8'h20, 16'hFFFF);
    rd_chk(8'h20, 16'h0000);
    for (int m = 0; m < 3; m++) begin
      wr(OFS_MODE, 16'(m));
      chk_word("mode", 16'(m), {14'h0000, mode});
      rd_chk(OFS_MODE, 16'(m));
    end
    foreach (codes[i]) begin
      wr(OFS_PIN_FUNC, {3'h0, codes[i], 3'h0, codes[i]});
      rd_chk(OFS_PIN_FUNC, {3'h0, codes[i], 3'h0, codes[i]});
      foreach (pats[j]) begin
        @(negedge clk_sys);
        src = pats[j];
        @(negedge clk_sys);
        src[1:0] = 2'h0;
        chk_pin("pin 0", want(codes[i], 1'b0, pats[j]), {p0_oe_n, p0_out});
        chk_pin("pin 1", want(codes[i], 1'b1, pats[j]), {p1_oe_n, p1_out});
      end
    end
    wr(OFS_PIN_FUNC, {3'h0, FN_TOGGLE, 3'h0, FN_TOGGLE});
    repeat (2) begin
      @(negedge clk_sys);
      lvl = p0_out;
      smp_done = 1'b1;
      @(negedge clk_sys);
      smp_done = 1'b0;
      @(negedge clk_sys);
      chk_pin("toggle", {1'b0, ~lvl}, {p0_oe_n, p0_out});
    end
    wr(OFS_PIN_FUNC, {3'h0, FN_SLOW_CLK, 3'h0, FN_SLOW_CLK});
    repeat (2) begin
      @(slow_clk);
      repeat (10) @(negedge clk_sys);
      chk_pin("slow clock", {1'b0, slow_clk}, {p1_oe_n, p1_out});
    end
    addr_exp = ADDR_RESET;
    foreach (ucase[i]) begin
      wr(OFS_PIN_FUNC, {3'h0, ucase[i][1] ? FN_HIGH : FN_LOW, 3'h0,
         ucase[i][2] ? FN_HIGH : FN_LOW});
      wr(OFS_UNLOCK, ucase[i][26:11]);
      rd_chk(OFS_UNLOCK, ucase[i][26:11]);
      repeat (4) @(negedge clk_sys);
      wr(OFS_TARGET_ADDR, {ucase[i][10:3], 7'(8'h30 + i), 1'b0});
      if (ucase[i][0]) addr_exp = 7'(8'h30 + i);
      rd_chk(OFS_TARGET_ADDR, {8'h00, addr_exp, 1'b0});
      chk_word("target", {9'h000, addr_exp}, {9'h000, target});
    end
    cal_en = 1'b1;
    wr(OFS_OSC_RATIO, 16'h0FFF);
    rd_chk(OFS_OSC_RATIO, 16'h0000);
    n = 0;
    while (d === 16'h0000 && n < 200) begin
      repeat (100) @(negedge clk_sys);
      rd(OFS_OSC_RATIO);
      n++;
    end
    // Synchroniser jitter and oscillator rounding allow a few counts.
    chk_word("ratio near", 16'h0001, {15'h0000, d >= 1995 && d <= 2005});
    cal_en = 1'b0;
    wr(OFS_MODE, {14'h0000, MODE_NORMAL});
    wr(OFS_SOFT_RESET, 16'h0001);
    chk_word("soft reset", 16'h0001, {15'h0000, soft_out});
    @(negedge clk_sys);
    chk_word("soft reset end", 16'h0000, {15'h0000, soft_out});
    chk_defaults();
    end_sim();
  end
endmodule
`default_nettype wire
